// *** core/pio_pkg.sv ***
// Package: register map, field layout and state record of the parallel ports
//
// Function
// - Three 8-bit bidirectional ports, one input-only
// - Direction bit one drives pin, zero inputs
// - Reset clears every direction register
// - Direction registers read back last written value, but port C bit two reads one under clock select
// - Data write with direction zero: latch only
// - Data write with direction one: drives pin
// - Input bit read returns sampled pin
// - Output bit read returns the latch
// - Reset leaves data latches untouched
// - Wired-OR enable: high port B input pin requests interrupt
// - Clock select: pin two outputs clock, forced
// - Other port C pins stay ordinary
// - Clock select cleared by reset or by writing its bit zero
// - Control register upper nibble zero, resets zero
// - Input-only port has no direction register
// - Converter power bit selects analog pin use
// - Input-only port readable at any time
// - Data at 0x0-0x3, direction at 0x4-0x6
package pio_pkg;

  localparam int         PORT_W      = 8;
  localparam logic [7:0] IDX_PA      = 8'h00;
  localparam logic [7:0] IDX_PB      = 8'h01;
  localparam logic [7:0] IDX_PC      = 8'h02;
  localparam logic [7:0] IDX_PD      = 8'h03;
  localparam logic [7:0] IDX_DIR_A   = 8'h04;
  localparam logic [7:0] IDX_DIR_B   = 8'h05;
  localparam logic [7:0] IDX_DIR_C   = 8'h06;
  localparam logic [7:0] IDX_CLK_CTL = 8'h07;
  localparam logic [7:0] IDX_ADC_CTL = 8'h09;
  localparam logic [7:0] IDX_WOI_CTL = 8'h0A;
  localparam int         BIT_CLK_SEL = 3;
  localparam int         BIT_ADC_ON  = 5;
  localparam int         BIT_WIRED_OR_IRQ_ENABLE    = 0;
  localparam int         IDX_LSB     = 2;
  localparam int         IDX_MSB     = 9;
  localparam logic [7:0] CLK_PIN_MSK = 8'h04;
  localparam logic [7:0] DIR_RST     = 8'h00;
  localparam logic [7:0] BYTE_ZERO   = 8'h00;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [2:0][7:0] dir;
    logic [2:0][7:0] lat;
    logic [3:0][7:0] s1;
    logic [3:0][7:0] s2;
    logic            clk_sel;
    logic            adc_on;
    logic            wired_or_irq_enable;
    logic            irq;
    logic            aw_got;
    logic [7:0]      aw_idx;
    logic            w_got;
    logic [7:0]      wd;
    logic            we0;
    logic            bvalid;
    logic [1:0]      bresp;
    logic            rvalid;
    logic [1:0]      rresp;
    logic [7:0]      rdata;
  } pio_state_type;

endpackage : pio_pkg

// *** core/pio_ports.sv ***
// Parallel port block: three bidirectional ports, input-only port, AXI4-Lite slave
`timescale 1ns/1ps
module pio_ports
  import pio_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic              ce,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [7:0]        pa_i,
  output logic [7:0]             pa_o,
  output logic [7:0]             pa_oe_n,
  input  wire logic [7:0]        pb_i,
  output logic [7:0]             pb_o,
  output logic [7:0]             pb_oe_n,
  input  wire logic [7:0]        pc_i,
  output logic [7:0]             pc_o,
  output logic [7:0]             pc_oe_n,
  input  wire logic [7:0]        input_only_pins,
  output logic                   converter_power_on,
  output logic                   woi_req
);

  pio_state_type s_r;
  pio_state_type s_nxt;
  logic [2:0][7:0] dir_eff;
  logic [7:0]      clk_msk;
  logic [7:0]      ar_idx;
  logic [7:0]      rd_byte;
  logic            rd_ok;
  logic            wr_ok;
  logic            aw_hs;
  logic            w_hs;
  logic            ar_hs;

  assign clk_msk = s_r.clk_sel ? CLK_PIN_MSK : BYTE_ZERO;
  assign ar_idx  = s_axi_araddr[IDX_MSB:IDX_LSB];
  assign aw_hs   = s_axi_awvalid && s_axi_awready;
  assign w_hs    = s_axi_wvalid && s_axi_wready;
  assign ar_hs   = s_axi_arvalid && s_axi_arready;

  // Clock select forces pin two of port C to output
  assign dir_eff[0] = s_r.dir[0];
  assign dir_eff[1] = s_r.dir[1];
  assign dir_eff[2] = s_r.dir[2] | clk_msk;

  // Pin drivers, one per bidirectional port
  logic [2:0][7:0] drv;
  genvar gp;
  generate
    for (gp = 0; gp < 3; gp++)
    begin : g_pin
      assign drv[gp] = s_r.lat[gp] & dir_eff[gp];
    end
  endgenerate

  assign pa_o    = drv[0];
  assign pa_oe_n = ~dir_eff[0];
  assign pb_o    = drv[1];
  assign pb_oe_n = ~dir_eff[1];
  assign pc_o    = (drv[2] & ~clk_msk) | ({PORT_W{clk}} & clk_msk);
  assign pc_oe_n = ~dir_eff[2];

  assign converter_power_on = s_r.adc_on;
  assign woi_req            = s_r.irq;

  assign s_axi_awready = ce && !s_r.aw_got;
  assign s_axi_wready  = ce && !s_r.w_got;
  assign s_axi_bvalid  = s_r.bvalid;
  assign s_axi_bresp   = s_r.bresp;
  assign s_axi_arready = ce && !s_r.rvalid;
  assign s_axi_rvalid  = s_r.rvalid;
  assign s_axi_rresp   = s_r.rresp;
  assign s_axi_rdata   = {24'h00_0000, s_r.rdata};

  // Read decode: input bits show pin, output bits show latch
  always_comb
  begin
    rd_byte = BYTE_ZERO;
    rd_ok   = 1'b1;
    case (ar_idx)
      IDX_PA:      rd_byte = (s_r.lat[0] & dir_eff[0]) | (s_r.s2[0] & ~dir_eff[0]);
      IDX_PB:      rd_byte = (s_r.lat[1] & dir_eff[1]) | (s_r.s2[1] & ~dir_eff[1]);
      IDX_PC:      rd_byte = (s_r.lat[2] & dir_eff[2]) | (s_r.s2[2] & ~dir_eff[2]);
      IDX_PD:      rd_byte = s_r.s2[3];
      IDX_DIR_A:   rd_byte = s_r.dir[0];
      IDX_DIR_B:   rd_byte = s_r.dir[1];
      IDX_DIR_C:   rd_byte = dir_eff[2];
      IDX_CLK_CTL: rd_byte[BIT_CLK_SEL] = s_r.clk_sel;
      IDX_ADC_CTL: rd_byte[BIT_ADC_ON] = s_r.adc_on;
      IDX_WOI_CTL: rd_byte[BIT_WIRED_OR_IRQ_ENABLE] = s_r.wired_or_irq_enable;
      default:     rd_ok = 1'b0;
    endcase
  end

  // Write decode of the held address
  always_comb
  begin
    case (s_r.aw_idx)
      IDX_PA, IDX_PB, IDX_PC, IDX_PD, IDX_DIR_A, IDX_DIR_B, IDX_DIR_C,
      IDX_CLK_CTL, IDX_ADC_CTL, IDX_WOI_CTL: wr_ok = 1'b1;
      default:                               wr_ok = 1'b0;
    endcase
  end

  always_comb
  begin
    s_nxt    = s_r;
    s_nxt.s1 = {input_only_pins, pc_i, pb_i, pa_i};
    s_nxt.s2 = s_r.s1;
    s_nxt.irq = s_r.wired_or_irq_enable && |(s_r.s2[1] & ~s_r.dir[1]);
    if (aw_hs)
    begin
      s_nxt.aw_got = 1'b1;
      s_nxt.aw_idx = s_axi_awaddr[IDX_MSB:IDX_LSB];
    end
    if (w_hs)
    begin
      s_nxt.w_got = 1'b1;
      s_nxt.wd    = s_axi_wdata[7:0];
      s_nxt.we0   = s_axi_wstrb[0];
    end
    if (s_r.bvalid && s_axi_bready)
    begin
      s_nxt.bvalid = 1'b0;
    end
    // Commit once address and data are both held
    if (s_r.aw_got && s_r.w_got && !s_r.bvalid)
    begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got  = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = wr_ok ? RESP_OKAY : RESP_SLVERR;
      if (s_r.we0)
      begin
        case (s_r.aw_idx)
          IDX_PA:      s_nxt.lat[0] = s_r.wd;
          IDX_PB:      s_nxt.lat[1] = s_r.wd;
          IDX_PC:      s_nxt.lat[2] = s_r.wd;
          IDX_DIR_A:   s_nxt.dir[0] = s_r.wd;
          IDX_DIR_B:   s_nxt.dir[1] = s_r.wd;
          IDX_DIR_C:   s_nxt.dir[2] = s_r.wd;
          IDX_CLK_CTL: s_nxt.clk_sel = s_r.wd[BIT_CLK_SEL];
          IDX_ADC_CTL: s_nxt.adc_on = s_r.wd[BIT_ADC_ON];
          IDX_WOI_CTL: s_nxt.wired_or_irq_enable = s_r.wd[BIT_WIRED_OR_IRQ_ENABLE];
          default:     s_nxt.we0 = s_r.we0;
        endcase
      end
    end
    if (s_r.rvalid && s_axi_rready)
    begin
      s_nxt.rvalid = 1'b0;
    end
    if (ar_hs)
    begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata  = rd_byte;
      s_nxt.rresp  = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    // Reset clears control state but keeps the data latches
    if (!rstn)
    begin
      s_nxt.dir     = {3{DIR_RST}};
      s_nxt.clk_sel = 1'b0;
      s_nxt.adc_on  = 1'b0;
      s_nxt.wired_or_irq_enable    = 1'b0;
      s_nxt.irq     = 1'b0;
      s_nxt.s1      = '0;
      s_nxt.s2      = '0;
      s_nxt.aw_got  = 1'b0;
      s_nxt.aw_idx  = BYTE_ZERO;
      s_nxt.w_got   = 1'b0;
      s_nxt.wd      = BYTE_ZERO;
      s_nxt.we0     = 1'b0;
      s_nxt.bvalid  = 1'b0;
      s_nxt.bresp   = RESP_OKAY;
      s_nxt.rvalid  = 1'b0;
      s_nxt.rresp   = RESP_OKAY;
      s_nxt.rdata   = BYTE_ZERO;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn || ce)
    begin
      s_r <= s_nxt;
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  logic wr_fire;
  assign wr_fire = s_r.aw_got && s_r.w_got && !s_r.bvalid && s_r.we0 && ce;

  property p_rst_dir;
    @(posedge clk) disable iff (1'b0)
    !rstn |=> (s_r.dir == '0) && !s_r.clk_sel && !s_r.adc_on;
  endproperty
  dir_reset_a: assert property (p_rst_dir)
    else $error("direction or control not cleared by reset");

  dir_to_pin_a: assert property (
    wr_fire && s_r.aw_idx == IDX_DIR_A |=> pa_oe_n == ~$past(s_r.wd))
    else $error("port A enable does not follow direction write");

  latch_only_a: assert property (
    wr_fire && s_r.aw_idx == IDX_PB && s_r.dir[1] == DIR_RST |=> pb_oe_n == 8'hFF)
    else $error("input pin driven after data write");

  drive_out_a: assert property (
    wr_fire && s_r.aw_idx == IDX_PA && s_r.dir[0] == 8'hFF |=> pa_o == $past(s_r.wd))
    else $error("written data not on output pins");

  sync_read_a: assert property (
    ce[*3] ##0 (ar_hs && ar_idx == IDX_PD) |=> s_axi_rdata[7:0] == $past(input_only_pins, 3))
    else $error("input-only port read not two stages behind pin");

  clk_out_a: assert property (
    s_r.clk_sel |-> !pc_oe_n[2] && pc_o[2] == clk && pc_oe_n[7:3] == ~s_r.dir[2][7:3])
    else $error("clock output pin wrong");

  ctl_upper_a: assert property (
    ar_hs && ar_idx == IDX_CLK_CTL |=> s_axi_rdata[7:4] == 4'h0)
    else $error("control upper nibble not zero");

  adc_sel_a: assert property (
    wr_fire && s_r.aw_idx == IDX_ADC_CTL |=> converter_power_on == $past(s_r.wd[BIT_ADC_ON]))
    else $error("converter power bit not applied");

  woi_req_a: assert property (
    ce && s_r.wired_or_irq_enable && |(s_r.s2[1] & ~s_r.dir[1]) |=> woi_req)
    else $error("wired-OR request missing");

  dir_read_a: assert property (
    ar_hs && ar_idx == IDX_DIR_B |=> s_axi_rdata[7:0] == $past(s_r.dir[1]))
    else $error("direction read differs from register");

  wr_resp_a: assert property (
    s_r.aw_got && s_r.w_got && !s_r.bvalid && ce |=> s_axi_bvalid)
    else $error("write response late");

  // Read path: input bits show the pin, output bits the latch
  in_bits_read_a: assert property (
    ar_hs && ar_idx == IDX_PA
    |=> (s_axi_rdata[7:0] & ~$past(dir_eff[0])) == ($past(s_r.s2[0]) & ~$past(dir_eff[0])))
    else $error("input bit read differs from synchronised pin");

  out_bits_read_a: assert property (
    ar_hs && ar_idx == IDX_PA
    |=> (s_axi_rdata[7:0] & $past(dir_eff[0])) == ($past(s_r.lat[0]) & $past(dir_eff[0])))
    else $error("output bit read differs from latch");

  clk_bit_read_a: assert property (
    ar_hs && ar_idx == IDX_PC && s_r.clk_sel |=> s_axi_rdata[2] == $past(s_r.lat[2][2]))
    else $error("clock pin read does not return latch");

  clk_dir_read_a: assert property (
    ar_hs && ar_idx == IDX_DIR_C && s_r.clk_sel |=> s_axi_rdata[2])
    else $error("clock pin direction not forced");

  other_c_pins_a: assert property (
    pc_o[7:3] == (s_r.lat[2][7:3] & s_r.dir[2][7:3])
    && pc_o[1:0] == (s_r.lat[2][1:0] & s_r.dir[2][1:0]))
    else $error("port C pin other than two disturbed");

  dir_pins_a: assert property (
    pa_oe_n == ~s_r.dir[0] && pb_oe_n == ~s_r.dir[1])
    else $error("pin enable differs from direction");

  pd_any_time_a: assert property (
    ar_hs && ar_idx == IDX_PD |=> s_axi_rvalid && s_axi_rresp == RESP_OKAY)
    else $error("input-only port read refused");

  pd_analog_read_a: assert property (
    ar_hs && ar_idx == IDX_PD && s_r.adc_on |=> s_axi_rdata[7:0] == $past(s_r.s2[3]))
    else $error("input-only port read wrong while converter on");

  bad_read_a: assert property (
    ar_hs && !rd_ok |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");

  bad_write_a: assert property (
    wr_fire && !wr_ok |=> s_axi_bresp == RESP_SLVERR)
    else $error("unmapped write not refused");

  good_write_a: assert property (
    wr_fire && wr_ok |=> s_axi_bresp == RESP_OKAY)
    else $error("mapped write refused");

  pd_no_dir_a: assert property (
    wr_fire && s_r.aw_idx == IDX_PD |=> s_r.dir == $past(s_r.dir))
    else $error("input-only port write disturbed directions");

  clk_sel_wr_a: assert property (
    wr_fire && s_r.aw_idx == IDX_CLK_CTL |=> s_r.clk_sel == $past(s_r.wd[BIT_CLK_SEL]))
    else $error("clock select not written");

  dir_b_wr_a: assert property (
    wr_fire && s_r.aw_idx == IDX_DIR_B |=> s_r.dir[1] == $past(s_r.wd))
    else $error("direction write not stored");

  woi_wr_a: assert property (
    wr_fire && s_r.aw_idx == IDX_WOI_CTL |=> s_r.wired_or_irq_enable == $past(s_r.wd[BIT_WIRED_OR_IRQ_ENABLE]))
    else $error("wired-OR enable not written");

  woi_off_a: assert property (
    ce && !s_r.wired_or_irq_enable |=> !woi_req)
    else $error("wired-OR request while disabled");

  woi_mask_a: assert property (
    ce && (s_r.s2[1] & ~s_r.dir[1]) == BYTE_ZERO |=> !woi_req)
    else $error("wired-OR request from output bit");

  rd_answer_a: assert property (
    ar_hs |=> s_axi_rvalid)
    else $error("read response late");

  // Clock enable low freezes control and handshake state
  ce_hold_a: assert property (
    !ce |=> s_r.dir == $past(s_r.dir) && s_r.clk_sel == $past(s_r.clk_sel)
    && s_r.bvalid == $past(s_r.bvalid) && s_r.rvalid == $past(s_r.rvalid))
    else $error("state moved while clock enable low");

  cov_write: cover property (wr_fire ##1 s_axi_bvalid && s_axi_bready);
  cov_read: cover property (ar_hs ##1 s_axi_rvalid && s_axi_rready);
  cov_clk: cover property (s_r.clk_sel && s_r.dir[2] != 8'hFF);
  cov_irq: cover property ($rose(woi_req));
  cov_freeze: cover property (!ce ##1 !ce);

endmodule : pio_ports

// *** test/pio_pin_model.sv ***
// Board-side model of the three bidirectional ports
`timescale 1ns/1ps
module pio_pin_model
(
  input  wire logic [2:0][7:0] ext,
  input  wire logic [2:0][7:0] drv,
  input  wire logic [2:0][7:0] drv_n,
  output logic      [2:0][7:0] lvl
);
  // A driven bit shows the block's value, an undriven one the board level
  assign lvl = (drv & ~drv_n) | (ext & drv_n);
endmodule : pio_pin_model

// *** test/testbench.sv ***
// Self-checking bench for the parallel port block
`timescale 1ns/1ps
module testbench
  import pio_pkg::*;
;
  logic            clk = 1'b0;
  logic            rstn = 1'b0;
  logic            ce = 1'b1;
  logic [11:0]     s_axi_awaddr = 12'h000;
  logic [11:0]     s_axi_araddr = 12'h000;
  logic            s_axi_awvalid = 1'b0;
  logic            s_axi_wvalid = 1'b0;
  logic            s_axi_arvalid = 1'b0;
  logic            s_axi_bready = 1'b1;
  logic            s_axi_rready = 1'b1;
  logic [31:0]     s_axi_wdata = 32'h0000_0000;
  logic [3:0]      s_axi_wstrb = 4'h1;
  logic            s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]      s_axi_bresp, s_axi_rresp;
  logic [31:0]     s_axi_rdata;
  logic [7:0]      pa_i, pa_o, pa_oe_n, pb_i, pb_o, pb_oe_n, pc_i, pc_o, pc_oe_n;
  logic [2:0][7:0] ext = '0;
  logic [7:0]      input_only_pins = 8'h00;
  logic            converter_power_on, woi_req;
  int              num_errors = 0;
  int              total_checks = 0;

  pio_ports pio_ports_i (.clk, .rstn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .pa_i, .pa_o, .pa_oe_n, .pb_i, .pb_o, .pb_oe_n, .pc_i, .pc_o,
    .pc_oe_n, .input_only_pins, .converter_power_on, .woi_req);

  pio_pin_model pio_pin_model_i (.ext(ext), .drv({pc_o, pb_o, pa_o}),
    .drv_n({pc_oe_n, pb_oe_n, pa_oe_n}), .lvl({pc_i, pb_i, pa_i}));

  initial
  begin
    forever #2 clk = ~clk;
  end

  task automatic results();
    if (num_errors == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic do_reset();
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
  endtask : do_reset

  // Address and data offered together, each released at its own handshake
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
    logic       ta, tw, a, w;
    logic [1:0] r;
    ta = 1'b0;
    tw = 1'b0;
    s_axi_awaddr  <= {2'b00, idx, 2'b00};
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= {24'h00_0000, d};
    s_axi_wvalid  <= 1'b1;
    while (!(ta && tw))
    begin
      @(posedge clk);
      a = s_axi_awready && !ta;
      w = s_axi_wready && !tw;
      if (a)
        s_axi_awvalid <= 1'b0;
      if (w)
        s_axi_wvalid <= 1'b0;
      ta = ta | a;
      tw = tw | w;
    end
    a = 1'b0;
    while (!a)
    begin
      @(posedge clk);
      a = s_axi_bvalid;
      r = s_axi_bresp;
    end
    chk($sformatf("bresp %h", idx), {6'h00, er}, {6'h00, r});
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [7:0] ed, input logic [1:0] er);
    logic        a;
    logic [31:0] d;
    logic [1:0]  r;
    a = 1'b0;
    s_axi_araddr  <= {2'b00, idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    while (!a)
    begin
      @(posedge clk);
      a = s_axi_arready;
    end
    s_axi_arvalid <= 1'b0;
    a = 1'b0;
    while (!a)
    begin
      @(posedge clk);
      a = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
    end
    chk($sformatf("rdata %h", idx), ed, d[7:0]);
    chk($sformatf("rdata high %h", idx), 8'h00, d[31:24] | d[23:16] | d[15:8]);
    chk($sformatf("rresp %h", idx), {6'h00, er}, {6'h00, r});
  endtask : rd

  initial
  begin
    repeat (5000) @(posedge clk);
    num_errors++;
    results();
  end

  initial
  begin
    do_reset();
    rd(IDX_DIR_A, DIR_RST, RESP_OKAY);
    rd(IDX_DIR_B, DIR_RST, RESP_OKAY);
    rd(IDX_DIR_C, DIR_RST, RESP_OKAY);
    rd(IDX_CLK_CTL, 8'h00, RESP_OKAY);
    rd(IDX_ADC_CTL, 8'h00, RESP_OKAY);
    ext[0] <= 8'h5A;
    wr(IDX_PA, 8'h3C, RESP_OKAY);
    @(negedge clk);
    chk("pa_oe_n", 8'hFF, pa_oe_n);
    chk("pa_i", 8'h5A, pa_i);
    @(posedge clk);
    wr(IDX_DIR_A, 8'hF0, RESP_OKAY);
    rd(IDX_DIR_A, 8'hF0, RESP_OKAY);
    rd(IDX_PA, 8'h3A, RESP_OKAY);
    @(negedge clk);
    chk("pa_oe_n", 8'h0F, pa_oe_n);
    chk("pa_i", 8'h3A, pa_i);
    @(posedge clk);
    // Wired-OR request only from input bits of port B
    wr(IDX_PB, 8'h00, RESP_OKAY);
    wr(IDX_DIR_B, 8'h0F, RESP_OKAY);
    wr(IDX_WOI_CTL, 8'h01, RESP_OKAY);
    ext[1] <= 8'h01;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk("woi_req out bit", 8'h00, {7'h00, woi_req});
    @(posedge clk);
    ext[1] <= 8'h10;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk("woi_req in bit", 8'h01, {7'h00, woi_req});
    @(posedge clk);
    wr(IDX_WOI_CTL, 8'h00, RESP_OKAY);
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("woi_req off", 8'h00, {7'h00, woi_req});
    @(posedge clk);
    // Clock output on port C pin two
    wr(IDX_PC, 8'h00, RESP_OKAY);
    ext[2] <= 8'hFF;
    wr(IDX_CLK_CTL, 8'hFF, RESP_OKAY);
    rd(IDX_CLK_CTL, 8'h08, RESP_OKAY);
    rd(IDX_DIR_C, 8'h04, RESP_OKAY);
    rd(IDX_PC, 8'hFB, RESP_OKAY);
    @(negedge clk);
    chk("pc_oe_n", 8'hFB, pc_oe_n);
    chk("clock pin low", 8'h00, {7'h00, pc_o[2]});
    @(posedge clk);
    #1;
    chk("clock pin high", 8'h01, {7'h00, pc_o[2]});
    @(posedge clk);
    // Input-only port and converter power bit
    input_only_pins <= 8'hC3;
    wr(IDX_ADC_CTL, 8'h20, RESP_OKAY);
    rd(IDX_ADC_CTL, 8'h20, RESP_OKAY);
    chk("converter_power_on", 8'h01, {7'h00, converter_power_on});
    wr(IDX_PD, 8'h00, RESP_OKAY);
    rd(IDX_PD, 8'hC3, RESP_OKAY);
    rd(8'h08, 8'h00, RESP_SLVERR);
    wr(8'h08, 8'h55, RESP_SLVERR);
    // Clock enable low freezes the block and refuses requests
    ce <= 1'b0;
    input_only_pins <= 8'h3C;
    repeat (3) @(posedge clk);
    chk("arready frozen", 8'h00, {7'h00, s_axi_arready});
    ce <= 1'b1;
    repeat (2) @(posedge clk);
    rd(IDX_PD, 8'h3C, RESP_OKAY);
    // Second reset: directions and selects clear, latches kept
    do_reset();
    rd(IDX_DIR_A, DIR_RST, RESP_OKAY);
    rd(IDX_CLK_CTL, 8'h00, RESP_OKAY);
    rd(IDX_ADC_CTL, 8'h00, RESP_OKAY);
    chk("pc_oe_n", 8'hFF, pc_oe_n);
    wr(IDX_DIR_A, 8'hFF, RESP_OKAY);
    rd(IDX_PA, 8'h3C, RESP_OKAY);
    wr(IDX_PA, 8'hA5, RESP_OKAY);
    rd(IDX_PA, 8'hA5, RESP_OKAY);
    chk("pa_i driven", 8'hA5, pa_i);
    results();
  end
endmodule : testbench
